// ==== core/slpp_defs.vh ====
`ifndef SLPP_DEFS_VH
`define SLPP_DEFS_VH

// ----------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------
`define SLPP_OFS_CTRL       8'h00
`define SLPP_OFS_LED_USB    8'h04
`define SLPP_OFS_OWNER      8'h08
`define SLPP_OFS_STATUS     8'h0c
`define SLPP_OFS_INT_STAT   8'h10
`define SLPP_OFS_INT_MASK   8'h14

// ----------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------
`define SLPP_CTRL_PWR_LSB   0
`define SLPP_CTRL_LED_EN    4
`define SLPP_CTRL_MODE_LSB  5
`define SLPP_CTRL_RESET     7'h00
`define SLPP_LED_USB_RESET  8'h00
`define SLPP_OWNER_RESET    8'h00
`define SLPP_MASK_RESET     4'h0

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define SLPP_ST_FIXSTRAP    0
`define SLPP_ST_FIXPORTS    2
`define SLPP_ST_POLARITY    5
`define SLPP_ST_CFG         6
`define SLPP_ST_SAMPLED     9
`define SLPP_ST_OC          10

// ----------------------------------------------------------------
// configuration method codes
// ----------------------------------------------------------------
`define SLPP_CFG_DEF_EMB    3'h0
`define SLPP_CFG_SMBUS      3'h1
`define SLPP_CFG_DEF_LEVEL  3'h2
`define SLPP_CFG_EEPROM     3'h3
`define SLPP_CFG_DEF_OWN    3'h4
`define SLPP_CFG_DEF_DUAL   3'h5

// ----------------------------------------------------------------
// led modes
// ----------------------------------------------------------------
`define SLPP_MODE_USB       2'h0
`define SLPP_MODE_OWN       2'h1
`define SLPP_MODE_DUAL      2'h2
`define SLPP_MODE_OFF       2'h3

// ----------------------------------------------------------------
// fixed-device strap decode
// ----------------------------------------------------------------
`define SLPP_FIX_NONE       3'h0
`define SLPP_FIX_P1         3'h1
`define SLPP_FIX_P12        3'h3
`define SLPP_FIX_P123       3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SLPP_SYNC_STAGES    2'h2

`endif

// ==== core/slpp_sync.v ====
`timescale 1ns/100ps

// ----------------------------------------------------------------
// two-stage synchroniser for pin inputs
// ----------------------------------------------------------------
module slpp_sync #(
    parameter WIDTH     = 1,
    parameter RESET_VAL = 0
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // data
    input  wire [WIDTH-1:0] d,
    output reg  [WIDTH-1:0] q
);

    reg [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= RESET_VAL[WIDTH-1:0];
            q    <= RESET_VAL[WIDTH-1:0];
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule // slpp_sync

// ==== core/slpp_core.v ====
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "slpp_defs.vh"

module slpp_core #(
    parameter PORTS = 4
) (
    // apb clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // apb slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [7:0]       paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    // straps
    input  wire [2:0]       cfg_sel_in,
    input  wire             power_polarity_strap,
    input  wire [1:0]       green_led_low_ports_in,
    // green led bank, ports 1..4
    output reg  [PORTS-1:0] green_led_bank_out,
    output reg  [PORTS-1:0] green_led_bank_oe,
    // second led bank, ports 1..4
    output reg  [PORTS-1:0] second_led_bank_out,
    output reg  [PORTS-1:0] second_led_bank_oe,
    // port power and over-current
    output wire [PORTS-1:0] port_power_enable_out,
    input  wire [PORTS-1:0] overcurrent_sense_in,
    // interrupt
    output reg              irq
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    wire [2:0]       cfg_s;
    wire             pol_s;
    wire [1:0]       fix_s;
    wire [PORTS-1:0] ocs_s;

    slpp_sync #(.WIDTH(6), .RESET_VAL(0)) u_sync_strap (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({cfg_sel_in, power_polarity_strap, green_led_low_ports_in}),
        .q       ({cfg_s, pol_s, fix_s})
    );

    // over-current pins idle high
    slpp_sync #(.WIDTH(PORTS), .RESET_VAL(15)) u_sync_oc (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (overcurrent_sense_in),
        .q       (ocs_s)
    );

    // ----------------------------------------------------------------
    // strap capture after reset release
    // ----------------------------------------------------------------
    reg  [1:0] smp_cnt;
    reg        sampled;
    reg  [2:0] cfg_q;
    reg        pol_q;
    reg  [1:0] fix_q;

    // wait for synchronisers to fill, then latch straps once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smp_cnt <= 2'h0;
            sampled <= 1'b0;
            cfg_q   <= 3'h0;
            pol_q   <= 1'b0;
            fix_q   <= 2'h0;
        end else if (!sampled) begin
            if (smp_cnt == `SLPP_SYNC_STAGES) begin
                sampled <= 1'b1;
                cfg_q   <= cfg_s;
                pol_q   <= pol_s;
                fix_q   <= fix_s;
            end else begin
                smp_cnt <= smp_cnt + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    reg  [3:0]       ctrl_pwr;
    reg              ctrl_led_en;
    reg  [1:0]       ctrl_mode;
    reg  [7:0]       led_usb;
    reg  [7:0]       owner;
    reg  [PORTS-1:0] int_stat;
    reg  [PORTS-1:0] int_mask;

    // control reset word; only the power field is sliced from it, led enable and mode reset to constants
    localparam [6:0] CTRL_RST = `SLPP_CTRL_RESET;

    wire wr_en = psel & penable & pwrite;
    wire rd_en = psel & ~penable & ~pwrite;
    wire set_p = psel & ~penable;

    // configuration-method decode
    reg        straps_en;
    reg        sw_cfg;
    reg  [1:0] led_mode;
    reg  [2:0] fixed_ports;

    always @* begin
        straps_en = 1'b0;
        sw_cfg    = 1'b0;
        led_mode  = `SLPP_MODE_OFF;
        case (cfg_q)
            `SLPP_CFG_DEF_EMB, `SLPP_CFG_DEF_LEVEL: begin
                straps_en = 1'b1;
                led_mode  = `SLPP_MODE_USB;
            end
            `SLPP_CFG_DEF_OWN: begin
                straps_en = 1'b1;
                led_mode  = `SLPP_MODE_OWN;
            end
            `SLPP_CFG_DEF_DUAL: begin
                led_mode  = `SLPP_MODE_DUAL;
            end
            `SLPP_CFG_SMBUS, `SLPP_CFG_EEPROM: begin
                sw_cfg    = 1'b1;
                led_mode  = ctrl_mode;
            end
            default: begin
                led_mode  = `SLPP_MODE_OFF;
            end
        endcase
    end

    // fixed-device strap decode
    always @* begin
        fixed_ports = `SLPP_FIX_NONE;
        if (straps_en) begin
            case (fix_q)
                2'h1:    fixed_ports = `SLPP_FIX_P1;
                2'h2:    fixed_ports = `SLPP_FIX_P12;
                2'h3:    fixed_ports = `SLPP_FIX_P123;
                default: fixed_ports = `SLPP_FIX_NONE;
            endcase
        end
    end

    // over-current: active low pins, event on assertion
    wire [PORTS-1:0] oc_live = ~ocs_s;
    reg  [PORTS-1:0] oc_prev;
    wire [PORTS-1:0] oc_evt  = oc_live & ~oc_prev & {PORTS{sampled}};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_prev <= {PORTS{1'b0}};
        end else begin
            oc_prev <= oc_live;
        end
    end

    // register writes; hardware set wins over write-one-to-clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_pwr    <= CTRL_RST[`SLPP_CTRL_PWR_LSB +: 4];
            ctrl_led_en <= 1'b0;
            ctrl_mode   <= `SLPP_MODE_USB;
            led_usb     <= `SLPP_LED_USB_RESET;
            owner       <= `SLPP_OWNER_RESET;
            int_stat    <= {PORTS{1'b0}};
            int_mask    <= `SLPP_MASK_RESET;
        end else begin
            if (wr_en && paddr == `SLPP_OFS_CTRL) begin
                ctrl_pwr    <= pwdata[`SLPP_CTRL_PWR_LSB +: 4];
                ctrl_led_en <= pwdata[`SLPP_CTRL_LED_EN];
                ctrl_mode   <= pwdata[`SLPP_CTRL_MODE_LSB +: 2];
            end
            if (wr_en && paddr == `SLPP_OFS_LED_USB) begin
                led_usb <= pwdata[7:0];
            end
            if (wr_en && paddr == `SLPP_OFS_OWNER) begin
                owner <= pwdata[7:0];
            end
            if (wr_en && paddr == `SLPP_OFS_INT_MASK) begin
                int_mask <= pwdata[PORTS-1:0];
            end
            if (wr_en && paddr == `SLPP_OFS_INT_STAT) begin
                int_stat <= (int_stat & ~pwdata[PORTS-1:0]) | oc_evt;
            end else begin
                int_stat <= int_stat | oc_evt;
            end
        end
    end

    // ----------------------------------------------------------------
    // apb read path and answer
    // ----------------------------------------------------------------
    reg        addr_ok;
    reg [31:0] rd_mux;

    always @* begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0000_0000;
        case (paddr)
            `SLPP_OFS_CTRL:
                rd_mux = {25'h0, ctrl_mode, ctrl_led_en, ctrl_pwr};
            `SLPP_OFS_LED_USB:
                rd_mux = {24'h0, led_usb};
            `SLPP_OFS_OWNER:
                rd_mux = {24'h0, owner};
            `SLPP_OFS_STATUS:
                rd_mux = {18'h0, oc_live, sampled, cfg_q, pol_q, fixed_ports, fix_q};
            `SLPP_OFS_INT_STAT:
                rd_mux = {28'h0, int_stat};
            `SLPP_OFS_INT_MASK:
                rd_mux = {28'h0, int_mask};
            default:
                addr_ok = 1'b0;
        endcase
    end

    // data and error prepared in setup, presented in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (set_p) begin
                pslverr <= ~addr_ok;
                prdata  <= rd_en ? rd_mux : 32'h0000_0000;
            end else if (!psel) begin
                pslverr <= 1'b0;
            end
        end
    end

    // level interrupt from unmasked sticky bits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat & int_mask);
        end
    end

    // ----------------------------------------------------------------
    // led drive
    // ----------------------------------------------------------------
    wire led_drive = sampled & (sw_cfg ? ctrl_led_en : 1'b1) & (led_mode != `SLPP_MODE_OFF);

    genvar gi;
    generate
        for (gi = 0; gi < PORTS; gi = gi + 1) begin : g_led
            reg green_lit;
            reg second_lit;
            reg green_hi;
            wire [1:0] code = owner[2*gi +: 2];

            // lit state per mode
            always @* begin
                green_lit  = 1'b0;
                second_lit = 1'b0;
                case (led_mode)
                    `SLPP_MODE_USB: begin
                        green_lit  = led_usb[gi];
                        second_lit = led_usb[PORTS+gi];
                    end
                    `SLPP_MODE_OWN: begin
                        green_lit  = (code == 2'h1);
                        second_lit = (code == 2'h2);
                    end
                    `SLPP_MODE_DUAL: begin
                        green_lit  = code[0];
                        second_lit = code[1];
                    end
                    default: begin
                        green_lit  = 1'b0;
                        second_lit = 1'b0;
                    end
                endcase
            end

            // polarity of the green pin
            always @* begin
                green_hi = 1'b0;
                if (gi < 2 && straps_en) begin
                    green_hi = ~fix_q[gi % 2];
                end else begin
                    green_hi = 1'b0;
                end
            end

            // pins tristated in reset so straps and led stay off
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    green_led_bank_out[gi]  <= 1'b1;
                    green_led_bank_oe[gi]   <= 1'b0;
                    second_led_bank_out[gi] <= 1'b1;
                    second_led_bank_oe[gi]  <= 1'b0;
                end else begin
                    green_led_bank_oe[gi]   <= led_drive;
                    second_led_bank_oe[gi]  <= led_drive;
                    green_led_bank_out[gi]  <= green_hi ? green_lit : ~green_lit;
                    second_led_bank_out[gi] <= ~second_lit;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // port power
    // ----------------------------------------------------------------
    reg [PORTS-1:0] pwr_q;

    // power off while over-current is present
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q <= {PORTS{1'b0}};
        end else begin
            pwr_q <= ctrl_pwr[PORTS-1:0] & ~oc_live;
        end
    end

    // live strap sets inactive level until the latch is taken
    assign port_power_enable_out = sampled ?
                                   (pol_q ? pwr_q : ~pwr_q) :
                                   {PORTS{~power_polarity_strap}};

endmodule // slpp_core

// ==== sim/slpp_core_asserts.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------
// port checks for strap sampling, led and power polarity
// ----------------------------------------------------------------
module slpp_core_chk #(
    parameter PORTS = 4
) (
    // clock and reset
    input wire             pclk,
    input wire             presetn,
    // apb
    input wire             psel,
    input wire             penable,
    input wire [7:0]       paddr,
    input wire             pready,
    input wire             pslverr,
    // straps and pins
    input wire [2:0]       cfg_sel_in,
    input wire             power_polarity_strap,
    input wire [PORTS-1:0] green_led_bank_oe,
    input wire [PORTS-1:0] second_led_bank_oe,
    input wire [PORTS-1:0] port_power_enable_out,
    input wire [PORTS-1:0] overcurrent_sense_in
);
    logic [1:0] cnt;
    logic       pol_l;
    logic [2:0] cfg_l;

    // edges since reset release, straps copied at the first one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt   <= 2'h0;
            pol_l <= 1'b0;
            cfg_l <= 3'h0;
        end else begin
            if (cnt != 2'h3) begin
                cnt <= cnt + 2'h1;
            end
            if (cnt == 2'h0) begin
                pol_l <= power_polarity_strap;
                cfg_l <= cfg_sel_in;
            end
        end
    end

    pwr_in_reset_a: assert property (@(posedge pclk)
        !presetn |-> port_power_enable_out == {PORTS{~power_polarity_strap}})
        else $error("power enable active in reset");
    led_dark_rst_a: assert property (@(posedge pclk)
        !presetn |-> (green_led_bank_oe | second_led_bank_oe) == '0)
        else $error("led driven in reset");
    led_dark_pre_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnt != 2'h3 |-> (green_led_bank_oe | second_led_bank_oe) == '0)
        else $error("led driven before straps sampled");
    pwr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnt == 2'h3 && $changed(power_polarity_strap) |-> $stable(port_power_enable_out))
        else $error("power follows live strap after reset");
    oc_power_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cnt == 2'h3 && !overcurrent_sense_in[0]) [*5] |->
        port_power_enable_out[0] == ~pol_l)
        else $error("port power on during over-current");
    cfg_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_l[2:1] == 2'b11 |-> (green_led_bank_oe | second_led_bank_oe) == '0)
        else $error("led driven under reserved code");
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable |-> pready)
        else $error("access phase without ready");
    apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && paddr > 8'h14 |-> pslverr)
        else $error("unmapped access without error");
    apb_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access with error");
endmodule // slpp_core_chk

bind slpp_core slpp_core_chk #(.PORTS(PORTS)) i_chk (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .paddr                 (paddr),
    .pready                (pready),
    .pslverr               (pslverr),
    .cfg_sel_in            (cfg_sel_in),
    .power_polarity_strap  (power_polarity_strap),
    .green_led_bank_oe     (green_led_bank_oe),
    .second_led_bank_oe    (second_led_bank_oe),
    .port_power_enable_out (port_power_enable_out),
    .overcurrent_sense_in  (overcurrent_sense_in)
);

// ==== sim/slpp_board.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------
// board side: strap resistors and current monitors
// ----------------------------------------------------------------
module slpp_board #(
    parameter PORTS = 4
) (
    // settings from the bench
    input  wire             pol_set,
    input  wire [1:0]       fix_set,
    input  wire [PORTS-1:0] fault,
    // pins
    input  wire [PORTS-1:0] green_led_bank_out,
    input  wire [PORTS-1:0] green_led_bank_oe,
    output wire             power_polarity_strap,
    output wire [1:0]       green_led_low_ports_in,
    output wire [PORTS-1:0] overcurrent_sense_in
);
    // polarity strap resistor
    assign power_polarity_strap = pol_set;
    // led pins: device drive wins, else the strap resistor level
    assign green_led_low_ports_in = (green_led_bank_oe[1:0] & green_led_bank_out[1:0])
                                  | (~green_led_bank_oe[1:0] & fix_set);
    // monitor pulls low on fault, pull-up holds high otherwise
    assign overcurrent_sense_in = ~fault;
endmodule // slpp_board

// ==== sim/test_strap_led_power_polarity.sv ====
`timescale 1ns/100ps
`include "slpp_defs.vh"

// ----------------------------------------------------------------
// bench for strap, led and power polarity block
// ----------------------------------------------------------------
module test_strap_led_power_polarity;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, pol_set, pps;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [2:0]  cfg_sel_in;
    logic [1:0]  fix_set, glp;
    logic [3:0]  g_out, g_oe, s_out, s_oe, ppe, ocs, fault, m;
    logic [32:0] expq[$];
    logic [31:0] rows [6] = '{32'h4300c912, 32'h50003956, 32'h10503956, 32'h60503900,
                              32'h30303912, 32'h21003920};
    logic [2:0]  dec [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    int          n_errors, comparisons;

    slpp_core #(.PORTS(4)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfg_sel_in(cfg_sel_in), .power_polarity_strap(pps), .green_led_low_ports_in(glp),
        .green_led_bank_out(g_out), .green_led_bank_oe(g_oe), .second_led_bank_out(s_out),
        .second_led_bank_oe(s_oe), .port_power_enable_out(ppe),
        .overcurrent_sense_in(ocs), .irq(irq));
    slpp_board #(.PORTS(4)) i_board (
        .pol_set(pol_set), .fix_set(fix_set), .fault(fault), .green_led_bank_out(g_out),
        .green_led_bank_oe(g_oe), .power_polarity_strap(pps), .green_led_low_ports_in(glp),
        .overcurrent_sense_in(ocs));

    // clock
    always #2 pclk = ~pclk;

    task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic pin(input string nm, input logic [3:0] s, input logic [3:0] e);
        chk(nm, {29'h0, s}, {29'h0, e});
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // expected {error, data} noted before the read goes out
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic boot(input logic [2:0] c, input logic p, input logic [1:0] fx);
        @(posedge pclk);
        cfg_sel_in <= c;
        pol_set    <= p;
        fix_set    <= fx;
        presetn    <= 1'b0;
        repeat (3) @(posedge pclk);
        pin("rst_power", ppe, {4{~p}});
        pin("rst_led", g_oe | s_oe, 4'h0);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
    endtask

    // read monitor: oldest note against each completed read
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            chk("read", {pslverr, prdata}, expq.pop_front());
        end
    end

    // watchdog
    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        final_report();
    end

    // main sequence
    initial begin
        {pclk, psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b1; // first boot makes a clean falling edge
        {cfg_sel_in, pol_set, fix_set, fault} = '0;
        void'($urandom(32'h08a9));
        for (int f = 0; f < 4; f++) begin
            boot(3'h0, f[0], f[1:0]);
            rd(`SLPP_OFS_STATUS, {23'h0, 1'b1, 3'h0, f[0], dec[f], f[1:0]});
            wr(`SLPP_OFS_LED_USB, 32'h3);
            wr(`SLPP_OFS_CTRL, 32'hf);
            repeat (3) @(posedge pclk);
            pin("green_lit", g_oe & (g_out ^ {2'h3, f[1:0]}), 4'h3);
            pin("power_on", ppe, {4{f[0]}});
            pol_set <= ~f[0];
            repeat (3) @(posedge pclk);
            pin("power_latched", ppe, {4{f[0]}});
        end
        $display("strap and polarity test done");
        for (int i = 0; i < 6; i++) begin
            r = rows[i];
            boot(r[30:28], 1'b1, r[25:24]);
            if (r[20]) begin
                pin("leds_off", g_oe | s_oe, 4'h0);
            end
            wr(`SLPP_OFS_OWNER, {24'h0, r[15:8]});
            wr(`SLPP_OFS_CTRL, {24'h0, r[23:16]});
            repeat (3) @(posedge pclk);
            pin("green_own", g_oe & ~g_out, r[7:4]);
            pin("second_own", s_oe & ~s_out, r[3:0]);
        end
        $display("ownership test done");
        boot(3'h0, 1'b0, 2'h3);
        m = {3'($urandom % 8), 1'b1};
        wr(`SLPP_OFS_CTRL, 32'hf);
        fault <= m;
        repeat (8) @(posedge pclk);
        pin("oc_power", ppe, m);
        pin("irq_masked", {3'h0, irq}, 4'h0);
        rd(`SLPP_OFS_INT_STAT, {29'h0, m});
        wr(`SLPP_OFS_INT_MASK, 32'hf);
        repeat (3) @(posedge pclk);
        pin("irq_set", {3'h0, irq}, 4'h1);
        fault <= 4'h0;
        wr(`SLPP_OFS_INT_STAT, {28'h0, m});
        repeat (3) @(posedge pclk);
        pin("irq_clear", {3'h0, irq}, 4'h0);
        rd(`SLPP_OFS_INT_STAT, 33'h0);
        rd(8'h18, {1'b1, 32'h0});
        repeat (3) @(posedge pclk);
        $display("over-current test done");
        final_report();
    end
endmodule // test_strap_led_power_polarity
